/* src/mis_consts.svh */
// Register offsets, field positions and reset values for the status block
`ifndef MIS_CONSTS_SVH
`define MIS_CONSTS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define MIS_ADDR_STATUS_ONE   8'h41
`define MIS_ADDR_STATUS_TWO   8'h42
`define MIS_ADDR_MASK_ONE     8'h70
`define MIS_ADDR_MASK_TWO     8'h71

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define MIS_STATUS_RESET      8'h00
`define MIS_MASK_RESET        8'h00
`define MIS_RDATA_IDLE        8'h00

// ---------------------------------------------------------------
// Status one fields
// ---------------------------------------------------------------
`define MIS_S1_VOLT_LSB       0
`define MIS_S1_TEMP_LSB       4
`define MIS_S1_ANY_TWO        7

// ---------------------------------------------------------------
// Status two fields
// ---------------------------------------------------------------
`define MIS_S2_TWELVE_V       0
`define MIS_S2_OVERTEMP       1
`define MIS_S2_FAN_LSB        2
`define MIS_S2_DIODE_LSB      6

// ---------------------------------------------------------------
// Channel counts and hysteresis
// ---------------------------------------------------------------
`define MIS_NUM_VOLT          5
`define MIS_NUM_TEMP          3
`define MIS_NUM_FAN           4
`define MIS_NUM_PWM           3
`define MIS_NUM_DIODE         2
`define MIS_OVT_HYST_DEG      9'sd4

`endif

/* src/mis_pkg.sv */
// Types shared by the status block
package mis_pkg;
  typedef logic [7:0]  mis_byte_type;
  typedef logic [15:0] mis_word_type;
endpackage : mis_pkg

/* src/mis_limit_cmp.sv */
// Window comparator: high above limit, low at or below limit
`timescale 1ns/1ps
module mis_limit_cmp #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] i_value,
  input  wire logic [W-1:0] i_low,
  input  wire logic [W-1:0] i_high,
  input  wire logic         i_low_en,
  output logic              o_out
);
  // [R13] strict above, low inclusive
  assign o_out = (i_value > i_high) || (i_low_en && (i_value <= i_low));
endmodule : mis_limit_cmp

/* src/mis_flag_bank.sv */
// Sticky flags that clear on a read once their condition has gone
`timescale 1ns/1ps
module mis_flag_bank #(
  parameter int N = 8
) (
  input  wire logic         i_clock,
  input  wire logic         i_rstn,
  input  wire logic [N-1:0] i_set,
  input  wire logic [N-1:0] i_hold,
  input  wire logic         i_read,
  output logic      [N-1:0] o_flags
);
  logic [N-1:0] flags_r;
  logic [N-1:0] flags_nxt;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      // [R3] read clears only once condition gone; set wins
      assign flags_nxt[g] = i_set[g] |
                            (flags_r[g] & ~(i_read & ~i_hold[g]));
    end
  endgenerate

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign o_flags = flags_r;
endmodule : mis_flag_bank

/* src/mis_status.sv */
// Interrupt status registers of the hardware monitor, with mask and irq
`timescale 1ns/1ps
`include "mis_consts.svh"

// Notes on behaviour
// [R1] Status one bits 0-3 latch 2.5 V, core, own supply, 5 V limit events.
// [R2] Status one bits 4-6 latch remote one, local, remote two temp events.
// [R3] Limit flags hold until read; read clears only if condition gone.
// [R4] Status one bit 7 reads as OR of all status two bits.
// [R5] Status one sits at 0x41 and resets to zero.
// [R6] Status two at 0x42; bit 0 latches 12 V limit events.
// [R7] Status two bit 1 sets when any temp exceeds its overtemp limit.
// [R8] Overtemp flag clears on read only below limit minus four degrees.
// [R9] Status two bits 2-5 latch fans one to four slow or stalled.
// [R10] Fans one to three flags suppressed while matching drive is off.
// [R11] Fan four flag suppressed while third drive is off.
// [R12] Status two bits 6-7 latch diode one and two open or short.
// [R13] High event is strictly above limit; low event at or below.
// [R14] Fan slow when tach count exceeds minimum limit by one or more.
// [R15] Writes to either status register are ignored.
// [R16] Fan and diode flags also clear on read only once condition gone.
module mis_status (
  input  wire logic                 i_clock,
  input  wire logic                 i_rstn,
  input  wire mis_pkg::mis_byte_type i_addr,
  input  wire mis_pkg::mis_byte_type i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output mis_pkg::mis_byte_type     o_rdata,
  output logic                      o_irq,
  input  wire logic [39:0]          i_volt_value,
  input  wire logic [39:0]          i_volt_low,
  input  wire logic [39:0]          i_volt_high,
  input  wire logic [23:0]          i_temp_value,
  input  wire logic [23:0]          i_temp_low,
  input  wire logic [23:0]          i_temp_high,
  input  wire logic [23:0]          i_overtemp_limit,
  input  wire logic [63:0]          i_tach_count,
  input  wire logic [63:0]          i_tach_min,
  input  wire logic [2:0]           i_pwm_on,
  input  wire logic [1:0]           i_diode_fault
);
  import mis_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [4:0]   volt_ev;
  logic [2:0]   temp_ev;
  logic [3:0]   fan_slow;
  logic [3:0]   fan_ev;
  logic [2:0]   ovt_over;
  logic [2:0]   ovt_band;
  logic         ovt_set;
  logic         ovt_hold;
  logic [6:0]   set_one;
  logic [7:0]   set_two;
  logic [7:0]   hold_two;
  logic [6:0]   flags_one;
  logic [7:0]   flags_two;
  logic         any_two;
  mis_byte_type status_one_val;
  mis_byte_type mask_one_r;
  mis_byte_type mask_one_nxt;
  mis_byte_type mask_two_r;
  mis_byte_type mask_two_nxt;
  mis_byte_type rdata_r;
  mis_byte_type rdata_nxt;
  mis_byte_type read_mux;
  logic         sel_one;
  logic         sel_two;
  logic         sel_mask_one;
  logic         sel_mask_two;
  logic         read_one;
  logic         read_two;

  // ---------------------------------------------------------------
  // Voltage comparators
  // ---------------------------------------------------------------
  genvar v;
  generate
    for (v = 0; v < `MIS_NUM_VOLT; v++) begin : g_volt
      // [R1] voltage window check
      mis_limit_cmp #(.W(8)) u_cmp (
        .i_value  (i_volt_value[v*8 +: 8]),
        .i_low    (i_volt_low[v*8 +: 8]),
        .i_high   (i_volt_high[v*8 +: 8]),
        .i_low_en (1'b1),
        .o_out    (volt_ev[v])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Temperature comparators
  // ---------------------------------------------------------------
  // Readings are two's complement; flipping the sign bit lets the
  // unsigned comparator order them correctly.
  genvar t;
  generate
    for (t = 0; t < `MIS_NUM_TEMP; t++) begin : g_temp
      logic signed [8:0] temp_ext;
      logic signed [8:0] lim_ext;
      // [R2] temperature window check
      mis_limit_cmp #(.W(8)) u_cmp (
        .i_value  (i_temp_value[t*8 +: 8] ^ 8'h80),
        .i_low    (i_temp_low[t*8 +: 8] ^ 8'h80),
        .i_high   (i_temp_high[t*8 +: 8] ^ 8'h80),
        .i_low_en (1'b1),
        .o_out    (temp_ev[t])
      );
      assign temp_ext = {i_temp_value[t*8+7], i_temp_value[t*8 +: 8]};
      assign lim_ext  = {i_overtemp_limit[t*8+7],
                         i_overtemp_limit[t*8 +: 8]};
      // [R7] above overtemp limit
      assign ovt_over[t] = temp_ext > lim_ext;
      // [R8] not yet below limit minus four; widened so it cannot wrap
      assign ovt_band[t] = temp_ext >= (lim_ext - `MIS_OVT_HYST_DEG);
    end
  endgenerate

  assign ovt_set  = |ovt_over;
  assign ovt_hold = |ovt_band;

  // ---------------------------------------------------------------
  // Fan comparators
  // ---------------------------------------------------------------
  genvar f;
  generate
    for (f = 0; f < `MIS_NUM_FAN; f++) begin : g_fan
      // [R14] count above minimum means slow
      mis_limit_cmp #(.W(16)) u_cmp (
        .i_value  (i_tach_count[f*16 +: 16]),
        .i_low    (16'h0000),
        .i_high   (i_tach_min[f*16 +: 16]),
        .i_low_en (1'b0),
        .o_out    (fan_slow[f])
      );
    end
  endgenerate

  // [R10] gate fans one to three by own drive
  assign fan_ev[2:0] = fan_slow[2:0] & i_pwm_on[2:0];
  // [R11] fan four shares the third drive
  assign fan_ev[3]   = fan_slow[3] & i_pwm_on[2];

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // [R5] [R6] status register addresses
  assign sel_one      = i_addr == `MIS_ADDR_STATUS_ONE;
  assign sel_two      = i_addr == `MIS_ADDR_STATUS_TWO;
  assign sel_mask_one = i_addr == `MIS_ADDR_MASK_ONE;
  assign sel_mask_two = i_addr == `MIS_ADDR_MASK_TWO;
  assign read_one     = i_rd && sel_one;
  assign read_two     = i_rd && sel_two;

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  // [R1] voltage bits into status one
  assign set_one = {temp_ev, volt_ev[3:0]};

  // [R6] [R9] [R12] status two layout
  assign set_two = {i_diode_fault, fan_ev, ovt_set, volt_ev[4]};
  // [R16] fan and diode flags hold while condition stays
  assign hold_two = {i_diode_fault, fan_ev, ovt_hold, volt_ev[4]};

  // [R3] clear on read of status one
  mis_flag_bank #(.N(7)) u_flags_one (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_set   (set_one),
    .i_hold  (set_one),
    .i_read  (read_one),
    .o_flags (flags_one)
  );

  // [R8] overtemp hold uses hysteresis band
  mis_flag_bank #(.N(8)) u_flags_two (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_set   (set_two),
    .i_hold  (hold_two),
    .i_read  (read_two),
    .o_flags (flags_two)
  );

  // [R4] summary of second register
  assign any_two        = |flags_two;
  assign status_one_val = {any_two, flags_one};

  // ---------------------------------------------------------------
  // Mask registers
  // ---------------------------------------------------------------
  // [R15] only masks take writes; status writes fall through
  assign mask_one_nxt = (i_wr && sel_mask_one) ? i_wdata : mask_one_r;
  assign mask_two_nxt = (i_wr && sel_mask_two) ? i_wdata : mask_two_r;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      mask_one_r <= `MIS_MASK_RESET;
      mask_two_r <= `MIS_MASK_RESET;
    end else begin
      mask_one_r <= mask_one_nxt;
      mask_two_r <= mask_two_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Data is captured at the same edge the flags clear, so software
  // always sees the value that caused the clear.
  assign read_mux = sel_one      ? status_one_val :
                    sel_two      ? flags_two      :
                    sel_mask_one ? mask_one_r     :
                    sel_mask_two ? mask_two_r     :
                    `MIS_RDATA_IDLE;
  assign rdata_nxt = i_rd ? read_mux : `MIS_RDATA_IDLE;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      rdata_r <= `MIS_RDATA_IDLE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;

  // ---------------------------------------------------------------
  // Interrupt
  // ---------------------------------------------------------------
  // Bit 7 of status one is masked like the others, so software may
  // take status two events through one mask bit.
  assign o_irq = |(status_one_val & mask_one_r) |
                 |(flags_two & mask_two_r);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  sequence s_read_one;
    i_rd && (i_addr == `MIS_ADDR_STATUS_ONE);
  endsequence

  sequence s_read_two;
    i_rd && (i_addr == `MIS_ADDR_STATUS_TWO);
  endsequence

  sequence s_write_status;
    i_wr && (sel_one || sel_two);
  endsequence

  // [R5] status one data the cycle after its read
  AST_READ_ONE_DATA: assert property ( // [R5]
    s_read_one |=> o_rdata == $past(status_one_val))
    else $error("status one read data wrong");

  // [R4] bit 7 follows status two
  AST_SUMMARY_BIT: assert property ( // [R4]
    s_read_one |=> o_rdata[7] == |$past(flags_two))
    else $error("summary bit not OR of status two");

  // [R1] voltage event latched
  AST_VOLT_LATCH: assert property ( // [R1]
    (i_volt_value[7:0] > i_volt_high[7:0]) |=> flags_one[0])
    else $error("voltage high event not latched");

  // [R3] read with condition gone clears
  AST_CLEAR_GONE: assert property ( // [R3]
    (flags_one[4] && !temp_ev[0]) ##0 s_read_one |=> !flags_one[4])
    else $error("flag survived read after condition gone");

  // [R3] read with condition present keeps flag
  AST_HOLD_PRESENT: assert property ( // [R3]
    (flags_two[0] && volt_ev[4]) ##0 s_read_two |=> flags_two[0])
    else $error("flag cleared while condition present");

  // [R8] inside hysteresis band the overtemp flag survives a read
  AST_OVT_HYST: assert property ( // [R8]
    (flags_two[1] && ovt_hold) ##0 s_read_two |=> flags_two[1])
    else $error("overtemp flag cleared inside hysteresis");

  // [R11] fan four stays quiet while third drive is off
  AST_FAN_GATED: assert property ( // [R11]
    (!i_pwm_on[2] && !flags_two[5]) |=> !flags_two[5])
    else $error("fan four flag set with drive off");

  // [R14] slow fan with drive on sets flag
  AST_FAN_SLOW: assert property ( // [R14]
    (i_tach_count[15:0] > i_tach_min[15:0] && i_pwm_on[0])
      |=> flags_two[2])
    else $error("fan one slow not latched");

  // [R15] status writes only ever add event bits, never clear
  AST_WRITE_IGNORED: assert property ( // [R15]
    s_write_status ##0 !i_rd
      |=> flags_two == ($past(flags_two) | $past(set_two)) &&
          flags_one == ($past(flags_one) | $past(set_one)))
    else $error("status write changed flags");

  // [R5] flags come out of reset clear
  AST_RESET_CLEAR: assert property ( // [R5]
    $rose(i_rstn) |-> status_one_val == `MIS_STATUS_RESET)
    else $error("status one not clear after reset");

  // [R5] read data idle outside the answer cycle
  AST_RDATA_IDLE: assert property ( // [R5]
    !i_rd |=> o_rdata == `MIS_RDATA_IDLE)
    else $error("read data not idle");

  // [R2] local temperature low event latched, signed compare
  AST_TEMP_LATCH: assert property ( // [R2]
    ($signed(i_temp_value[15:8]) <= $signed(i_temp_low[15:8]))
      |=> flags_one[5])
    else $error("temperature event not latched");

  // [R13] low event includes equality
  AST_LOW_EVENT: assert property ( // [R13]
    (i_volt_value[15:8] <= i_volt_low[15:8]) |=> flags_one[1])
    else $error("low limit event not latched");

  // [R6] twelve volt event latched in status two
  AST_TWELVE_LATCH: assert property ( // [R6]
    (i_volt_value[39:32] > i_volt_high[39:32]) |=> flags_two[0])
    else $error("twelve volt event not latched");

  // [R7] local reading above overtemp limit sets the flag
  AST_OVT_SET: assert property ( // [R7]
    ($signed(i_temp_value[15:8]) > $signed(i_overtemp_limit[15:8]))
      |=> flags_two[1])
    else $error("overtemp event not latched");

  // [R8] below the hysteresis band a read clears the flag
  AST_OVT_CLEAR: assert property ( // [R8]
    (flags_two[1] && !ovt_hold && !ovt_set) ##0 s_read_two
      |=> !flags_two[1])
    else $error("overtemp flag survived read below band");

  // [R10] fan one stays quiet while its drive is off
  AST_FAN_ONE_GATED: assert property ( // [R10]
    (!i_pwm_on[0] && !flags_two[2]) |=> !flags_two[2])
    else $error("fan one flag set with drive off");

  // [R12] diode two fault latched
  AST_DIODE_LATCH: assert property ( // [R12]
    i_diode_fault[1] |=> flags_two[7])
    else $error("diode two fault not latched");

  // [R16] diode flag survives a read while the fault stays
  AST_DIODE_HOLD: assert property ( // [R16]
    (flags_two[6] && i_diode_fault[0]) ##0 s_read_two |=> flags_two[6])
    else $error("diode flag cleared while fault present");

endmodule : mis_status

/* tb/tb_mis_status.sv */
// Self-checking bench for the monitor interrupt status block
`timescale 1ns/1ps
`include "mis_consts.svh"
module tb_mis_status;
  import mis_pkg::*;
  logic         i_clock          = 1'b0;
  logic         i_rstn           = 1'b0;
  mis_byte_type i_addr           = 8'h00;
  mis_byte_type i_wdata          = 8'h00;
  logic         i_wr             = 1'b0;
  logic         i_rd             = 1'b0;
  mis_byte_type o_rdata;
  logic         o_irq;
  logic [39:0]  i_volt_value     = {5{8'h80}};
  logic [39:0]  i_volt_low       = {5{8'h10}};
  logic [39:0]  i_volt_high      = {5{8'hf0}};
  logic [23:0]  i_temp_value     = {3{8'h20}};
  logic [23:0]  i_temp_low       = {3{8'h81}};
  logic [23:0]  i_temp_high      = {3{8'h7f}};
  logic [23:0]  i_overtemp_limit = {3{8'h50}};
  logic [63:0]  i_tach_count     = {4{16'h1000}};
  logic [63:0]  i_tach_min       = {4{16'h1000}};
  logic [2:0]   i_pwm_on         = 3'b111;
  logic [1:0]   i_diode_fault    = 2'b00;
  int           mismatches       = 0;
  int           n_tests          = 0;
  mis_byte_type a;
  mis_byte_type b;
  int           p;

  always #20 i_clock = ~i_clock;

  mis_status i_mis_status (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_irq(o_irq), .i_volt_value(i_volt_value),
    .i_volt_low(i_volt_low), .i_volt_high(i_volt_high),
    .i_temp_value(i_temp_value), .i_temp_low(i_temp_low),
    .i_temp_high(i_temp_high), .i_overtemp_limit(i_overtemp_limit),
    .i_tach_count(i_tach_count), .i_tach_min(i_tach_min),
    .i_pwm_on(i_pwm_on), .i_diode_fault(i_diode_fault));

  // ---------------------------------------------------------------
  // Bus tasks and checks
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask : tick

  task automatic chk(input mis_byte_type got, input mis_byte_type exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input mis_byte_type ad, input mis_byte_type d);
    @(posedge i_clock);
    i_addr  <= ad;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clock);
    i_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input mis_byte_type ad, input mis_byte_type exp);
    @(posedge i_clock);
    i_addr <= ad;
    i_rd   <= 1'b1;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    @(negedge i_clock);
    chk(o_rdata, exp);
  endtask : rd

  task automatic irq_is(input logic e);
    @(negedge i_clock);
    chk({7'h00, o_irq}, {7'h00, e});
  endtask : irq_is

  task automatic results;
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // Watchdog: the sequence is far shorter than this
  initial begin
    #2000000;
    mismatches++;
    results();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    tick(20);
    i_rstn <= 1'b1;
    rd(`MIS_ADDR_STATUS_ONE, 8'h00);
    rd(`MIS_ADDR_STATUS_TWO, 8'h00);
    rd(`MIS_ADDR_MASK_ONE, 8'h00);
    rd(`MIS_ADDR_MASK_TWO, 8'h00);
    rd(8'h55, 8'h00);
    irq_is(1'b0);
    // Boundary values that must not latch, signed temperature
    @(posedge i_clock);
    i_volt_value[7:0]  <= 8'hf0;
    i_volt_value[15:8] <= 8'h11;
    i_temp_value[7:0]  <= 8'h90;
    i_temp_value[23:16] <= 8'h50;
    tick(2);
    rd(`MIS_ADDR_STATUS_ONE, 8'h00);
    rd(`MIS_ADDR_STATUS_TWO, 8'h00);
    @(posedge i_clock);
    i_volt_value <= {5{8'h80}};
    i_temp_value <= {3{8'h20}};
    // Voltage lanes, alternating high and low events
    for (int k = 0; k < 5; k++) begin
      a = (k < 4) ? `MIS_ADDR_STATUS_ONE : `MIS_ADDR_STATUS_TWO;
      b = (k < 4) ? 8'(1 << k) : 8'h01;
      @(posedge i_clock);
      i_volt_value[8*k +: 8] <= (k % 2 == 0) ? 8'hf1 : 8'h10;
      tick(2);
      rd(a, b);
      @(posedge i_clock);
      i_volt_value[8*k +: 8] <= 8'h80;
      if (k == 4) begin
        rd(`MIS_ADDR_STATUS_ONE, 8'h80);
      end
      rd(a, b);
      rd(a, 8'h00);
      rd(`MIS_ADDR_STATUS_ONE, 8'h00);
    end
    // Temperature lanes at their signed low limit
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clock);
      i_temp_value[8*k +: 8] <= 8'h81;
      tick(2);
      @(posedge i_clock);
      i_temp_value[8*k +: 8] <= 8'h20;
      rd(`MIS_ADDR_STATUS_ONE, 8'(1 << (4 + k)));
      rd(`MIS_ADDR_STATUS_ONE, 8'h00);
    end
    // Overtemperature with four degrees of hysteresis
    @(posedge i_clock);
    i_temp_value[15:8] <= 8'h51;
    tick(2);
    @(posedge i_clock);
    i_temp_value[15:8] <= 8'h4c;
    rd(`MIS_ADDR_STATUS_TWO, 8'h02);
    rd(`MIS_ADDR_STATUS_TWO, 8'h02);
    @(posedge i_clock);
    i_temp_value[15:8] <= 8'h4b;
    rd(`MIS_ADDR_STATUS_TWO, 8'h02);
    rd(`MIS_ADDR_STATUS_TWO, 8'h00);
    // Fans, first with their drive off; fan four shares drive three
    for (int f = 0; f < 4; f++) begin
      p = (f < 3) ? f : 2;
      @(posedge i_clock);
      i_pwm_on[p] <= 1'b0;
      i_tach_count[16*f +: 16] <= 16'h1001;
      tick(2);
      rd(`MIS_ADDR_STATUS_TWO, 8'h00);
      @(posedge i_clock);
      i_pwm_on[p] <= 1'b1;
      tick(2);
      @(posedge i_clock);
      i_tach_count[16*f +: 16] <= 16'h1000;
      rd(`MIS_ADDR_STATUS_TWO, 8'(4 << f));
      rd(`MIS_ADDR_STATUS_TWO, 8'h00);
    end
    // Diode faults, held through reads, writes ignored
    for (int d = 0; d < 2; d++) begin
      b = 8'(8'h40 << d);
      @(posedge i_clock);
      i_diode_fault[d] <= 1'b1;
      tick(2);
      wr(`MIS_ADDR_STATUS_TWO, 8'h00);
      wr(`MIS_ADDR_STATUS_ONE, 8'h7f);
      rd(`MIS_ADDR_STATUS_ONE, 8'h80);
      rd(`MIS_ADDR_STATUS_TWO, b);
      rd(`MIS_ADDR_STATUS_TWO, b);
      @(posedge i_clock);
      i_diode_fault[d] <= 1'b0;
      rd(`MIS_ADDR_STATUS_TWO, b);
      rd(`MIS_ADDR_STATUS_TWO, 8'h00);
    end
    // Interrupt output against both masks
    @(posedge i_clock);
    i_diode_fault[0] <= 1'b1;
    tick(2);
    irq_is(1'b0);
    wr(`MIS_ADDR_MASK_TWO, 8'hbf);
    irq_is(1'b0);
    wr(`MIS_ADDR_MASK_ONE, 8'h80);
    irq_is(1'b1);
    wr(`MIS_ADDR_MASK_ONE, 8'h00);
    wr(`MIS_ADDR_MASK_TWO, 8'h40);
    irq_is(1'b1);
    rd(`MIS_ADDR_MASK_ONE, 8'h00);
    rd(`MIS_ADDR_MASK_TWO, 8'h40);
    @(posedge i_clock);
    i_diode_fault[0] <= 1'b0;
    rd(`MIS_ADDR_STATUS_TWO, 8'h40);
    irq_is(1'b0);
    results();
  end
endmodule : tb_mis_status
